// file: inc/aoctr_pkg.sv
// Package for the audio output clock and tone register bank.
// Assumes one 200 MHz system clock and a byte-wide register port.
package aoctr_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_PCM_FORMAT = 8'h55;
    localparam logic [7:0] OFS_CHANNEL_MAPPING = 8'h56;
    localparam logic [7:0] OFS_PLL_OUTPUT_DIVIDER = 8'h61;
    localparam logic [7:0] OFS_OVERSAMPLE_CLOCK_MODE = 8'h63;
    localparam logic [7:0] OFS_PLL_FRACTION_LOW = 8'h64;
    localparam logic [7:0] OFS_PLL_FRACTION_HIGH = 8'h65;
    localparam logic [7:0] OFS_DECODED_FRAMES_LOW = 8'h67;
    localparam logic [7:0] OFS_DECODED_FRAMES_MID = 8'h68;
    localparam logic [7:0] OFS_DECODED_FRAMES_HIGH = 8'h69;
    localparam logic [7:0] OFS_MEAN_STREAM_RATE = 8'h6A;
    localparam logic [7:0] OFS_FIRMWARE_REVISION = 8'h71;
    localparam logic [7:0] OFS_DECODE_START_CONTROL = 8'h72;
    localparam logic [7:0] OFS_HIGH_SHELF_CORNER_LOW = 8'h77;
    localparam logic [7:0] OFS_HIGH_SHELF_CORNER_HIGH = 8'h78;
    localparam logic [7:0] OFS_LOW_SHELF_CORNER_LOW = 8'h79;
    localparam logic [7:0] OFS_LOW_SHELF_CORNER_HIGH = 8'h7A;

    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [7:0] RST_PCM_FORMAT = 8'h21;
    localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
    localparam logic [7:0] RST_PLL_FRACTION_HIGH = 8'h5B;
    localparam logic [4:0] RST_PLL_OUTPUT_DIVIDER = 5'h00;
    localparam logic [7:0] RST_PCM_DIVIDER = 8'h01;
    localparam int SAMPLE_PRECISION_FIELD_LSB = 0;
    localparam int ALIGN_BIT = 4;
    localparam logic [1:0] SAMPLE_PRECISION_FIELD_16 = 2'h0;

    // ****************************************
    // Slot and frame sizes
    // ****************************************
    localparam logic [5:0] SLOTS_SHORT = 6'h10;
    localparam logic [5:0] SLOTS_LONG = 6'h20;
    localparam logic [6:0] BITS_PER_FRAME_SHORT = 7'h20;
    localparam logic [6:0] BITS_PER_FRAME_LONG = 7'h40;
    localparam logic [5:0] WORD_BITS_16 = 6'h10;
    localparam logic [5:0] WORD_BITS_18 = 6'h12;
    localparam logic [5:0] WORD_BITS_20 = 6'h14;
    localparam logic [5:0] WORD_BITS_24 = 6'h18;

    // Channel routing codes
    typedef enum logic [1:0] {
        aoctr_map_straight_t_v,
        aoctr_map_left_both_v,
        aoctr_map_right_both_v,
        aoctr_map_swap_v
    } aoctr_map_t;

    // Settings handed to the output and clock logic
    typedef struct packed {
        logic [5:0] word_bits;
        logic [5:0] slot_bits;
        logic [6:0] frame_bits;
        logic right_justify;
        logic [4:0] out_div;
        logic clock_fixed;
        logic [15:0] frac;
        logic [15:0] treble_hz;
        logic [15:0] bass_hz;
        logic run;
    } aoctr_cfg_t;

    // Host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aoctr_req_t;

endpackage

// file: hw/aoctr_regs.sv
// Register bank of the audio output, PLL clock and tone settings.
// Assumes the control bus front end delivers one-cycle rd/wr strobes.
// Notes on behaviour
// - Precision code picks word and slot size
// - 32 bit clocks per frame, else 64
// - Channel map: straight, left, right, swap
// - Five-bit divider X divides VCO by X+1
// - Core (in mode zero only) and host both write divider
// - Mode one holds oversampling clock fixed
// - Mode zero follows Fs, default 256
// - Fraction is high*256 plus low byte
// - Core loads fraction at frame sync in mode zero only
// - 24-bit frame counter, cleared on reset
// - Average bitrate halved, read-only byte
// - Firmware revision readable after boot
// - Start bit write one begins decoding
// - Treble corner 16-bit hertz value
// - Bass corner 16-bit hertz value
// - Alignment bit only for long words
// - Bit clock divider is 2(1+div)
`timescale 1ns/100ps
module aoctr_regs
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    // Host register port
    input wire aoctr_pkg::aoctr_req_t host_req,
    output logic [7:0] host_rdata,
    // Decoder core events
    input wire logic core_frame_done,
    input wire logic core_frame_sync,
    input wire logic core_boot_done,
    input wire logic [7:0] core_bitrate_half,
    input wire logic [7:0] core_fw_revision,
    input wire logic core_div_we,
    input wire logic [4:0] core_div_value,
    input wire logic [7:0] core_frac_low,
    input wire logic [7:0] core_frac_high,
    input wire logic [1:0] core_oversampling_clock_ratio,
    // Derived settings
    output aoctr_pkg::aoctr_cfg_t cfg,
    output logic [1:0] channel_mapping,
    output logic [7:0] oversampling_clock_fs_ratio_div,
    output logic [15:0] sck_half_div,
    output logic decoding
);
    localparam int MAP_W = 2;
    logic clr;
    logic [7:0] fmt_r;
    logic [7:0] pcm_div_r;
    logic [MAP_W-1:0] map_r;
    logic [4:0] div_r;
    logic mode_r;
    logic [7:0] frac_l_r;
    logic [7:0] frac_h_r;
    logic [23:0] frames_r;
    logic [7:0] rate_r;
    logic [7:0] fw_r;
    logic run_r;
    logic [7:0] tre_l_r, tre_h_r, bas_l_r, bas_h_r;
    logic [7:0] rdata_r;
    logic [1:0] sample_precision_field;
    logic [1:0] ratio_r;
    wire wr = host_req.wr;
    wire [7:0] a = host_req.addr;
    wire [7:0] d = host_req.wdata;

    assign clr = sys_rst | soft_rst;

    // ****************************************
    // Host writable registers, and the bit clock divider that only reset loads
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            fmt_r <= aoctr_pkg::RST_PCM_FORMAT;
            pcm_div_r <= aoctr_pkg::RST_PCM_DIVIDER;
            map_r <= '0;
            mode_r <= 1'b0;
            frac_h_r <= aoctr_pkg::RST_PLL_FRACTION_HIGH;
            run_r <= 1'b0;
            tre_l_r <= aoctr_pkg::RST_BYTE_ZERO;
            tre_h_r <= aoctr_pkg::RST_BYTE_ZERO;
            bas_l_r <= aoctr_pkg::RST_BYTE_ZERO;
            bas_h_r <= aoctr_pkg::RST_BYTE_ZERO;
        end
        else
        begin
            if (wr && a == aoctr_pkg::OFS_PCM_FORMAT)
                fmt_r <= d;
            if (wr && a == aoctr_pkg::OFS_CHANNEL_MAPPING)
                map_r <= d[MAP_W-1:0];
            if (wr && a == aoctr_pkg::OFS_OVERSAMPLE_CLOCK_MODE)
                mode_r <= d[0];
            if (core_frame_sync && !mode_r)
                frac_h_r <= core_frac_high;
            else if (wr && a == aoctr_pkg::OFS_PLL_FRACTION_HIGH)
                frac_h_r <= d;
            if (wr && a == aoctr_pkg::OFS_DECODE_START_CONTROL)
                run_r <= d[0];
            if (wr && a == aoctr_pkg::OFS_HIGH_SHELF_CORNER_LOW)
                tre_l_r <= d;
            if (wr && a == aoctr_pkg::OFS_HIGH_SHELF_CORNER_HIGH)
                tre_h_r <= d;
            if (wr && a == aoctr_pkg::OFS_LOW_SHELF_CORNER_LOW)
                bas_l_r <= d;
            if (wr && a == aoctr_pkg::OFS_LOW_SHELF_CORNER_HIGH)
                bas_h_r <= d;
        end
    end

    // Low fraction byte has no reset value
    always_ff @(posedge sys_clk)
    begin
        if (core_frame_sync && !mode_r)
            frac_l_r <= core_frac_low;
        else if (wr && a == aoctr_pkg::OFS_PLL_FRACTION_LOW)
            frac_l_r <= d;
    end

    // ****************************************
    // Divider shared by core and host
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (clr)
            div_r <= aoctr_pkg::RST_PLL_OUTPUT_DIVIDER;
        else if (core_div_we && !mode_r)
            div_r <= core_div_value;
        else if (wr && a == aoctr_pkg::OFS_PLL_OUTPUT_DIVIDER)
            div_r <= d[4:0];
    end

    // ****************************************
    // Core status
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            frames_r <= '0;
            rate_r <= aoctr_pkg::RST_BYTE_ZERO;
            fw_r <= aoctr_pkg::RST_BYTE_ZERO;
            ratio_r <= 2'h0;
        end
        else
        begin
            if (core_frame_done)
                frames_r <= frames_r + 24'h000001;
            if (core_frame_done)
                rate_r <= core_bitrate_half;
            if (core_boot_done)
                fw_r <= core_fw_revision;
            if (!mode_r && core_frame_sync)
                ratio_r <= core_oversampling_clock_ratio;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    logic [7:0] rmux;
    always_comb
    begin
        unique case (a)
            aoctr_pkg::OFS_PCM_FORMAT: rmux = fmt_r;
            aoctr_pkg::OFS_CHANNEL_MAPPING: rmux = {6'h00, map_r};
            aoctr_pkg::OFS_PLL_OUTPUT_DIVIDER: rmux = {3'h0, div_r};
            aoctr_pkg::OFS_OVERSAMPLE_CLOCK_MODE: rmux = {7'h00, mode_r};
            aoctr_pkg::OFS_PLL_FRACTION_LOW: rmux = frac_l_r;
            aoctr_pkg::OFS_PLL_FRACTION_HIGH: rmux = frac_h_r;
            aoctr_pkg::OFS_DECODED_FRAMES_LOW: rmux = frames_r[7:0];
            aoctr_pkg::OFS_DECODED_FRAMES_MID: rmux = frames_r[15:8];
            aoctr_pkg::OFS_DECODED_FRAMES_HIGH: rmux = frames_r[23:16];
            aoctr_pkg::OFS_MEAN_STREAM_RATE: rmux = rate_r;
            aoctr_pkg::OFS_FIRMWARE_REVISION: rmux = fw_r;
            aoctr_pkg::OFS_DECODE_START_CONTROL: rmux = {7'h00, run_r};
            aoctr_pkg::OFS_HIGH_SHELF_CORNER_LOW: rmux = tre_l_r;
            aoctr_pkg::OFS_HIGH_SHELF_CORNER_HIGH: rmux = tre_h_r;
            aoctr_pkg::OFS_LOW_SHELF_CORNER_LOW: rmux = bas_l_r;
            aoctr_pkg::OFS_LOW_SHELF_CORNER_HIGH: rmux = bas_h_r;
            default: rmux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            rdata_r <= 8'h00;
        else if (host_req.rd)
            rdata_r <= rmux;
    end
    assign host_rdata = rdata_r;

    // ****************************************
    // Derived settings
    // ****************************************
    assign sample_precision_field = fmt_r[aoctr_pkg::SAMPLE_PRECISION_FIELD_LSB +: 2];
    always_comb
    begin
        cfg = '0;
        unique case (sample_precision_field)
            2'h0: cfg.word_bits = aoctr_pkg::WORD_BITS_16;
            2'h1: cfg.word_bits = aoctr_pkg::WORD_BITS_18;
            2'h2: cfg.word_bits = aoctr_pkg::WORD_BITS_20;
            2'h3: cfg.word_bits = aoctr_pkg::WORD_BITS_24;
        endcase
        cfg.slot_bits = (sample_precision_field == aoctr_pkg::SAMPLE_PRECISION_FIELD_16) ? aoctr_pkg::SLOTS_SHORT
                                                     : aoctr_pkg::SLOTS_LONG;
        cfg.frame_bits = (sample_precision_field == aoctr_pkg::SAMPLE_PRECISION_FIELD_16) ? aoctr_pkg::BITS_PER_FRAME_SHORT
                                                      : aoctr_pkg::BITS_PER_FRAME_LONG;
        cfg.right_justify = (sample_precision_field != aoctr_pkg::SAMPLE_PRECISION_FIELD_16) && !fmt_r[aoctr_pkg::ALIGN_BIT];
        cfg.out_div = div_r;
        cfg.clock_fixed = mode_r;
        cfg.frac = {frac_h_r, frac_l_r};
        cfg.treble_hz = {tre_h_r, tre_l_r};
        cfg.bass_hz = {bas_h_r, bas_l_r};
        cfg.run = run_r;
    end

    assign channel_mapping = map_r;
    // Ratio code 0 is 256 x Fs, then 384, then 512
    assign oversampling_clock_fs_ratio_div = {6'h00, ratio_r};
    assign sck_half_div = {7'h00, pcm_div_r, 1'b0} + 16'h0002;
    assign decoding = run_r;

    // ****************************************
    // Checks
    // ****************************************
    sequence host_write_s(logic [7:0] o);
        wr && a == o && !clr;
    endsequence

    frame_count_a: assert property (@(posedge sys_clk) disable iff (clr)
        core_frame_done |=> frames_r == $past(frames_r) + 24'h000001)
        else $error("frame counter did not advance");
    frame_clear_a: assert property (@(posedge sys_clk)
        clr |=> frames_r == 24'h000000)
        else $error("frame counter not cleared");
    start_bit_a: assert property (@(posedge sys_clk)
        host_write_s(aoctr_pkg::OFS_DECODE_START_CONTROL) ##0 d[0] |=> decoding)
        else $error("start bit did not start decoding");
    frame_bits_a: assert property (@(posedge sys_clk) disable iff (clr)
        cfg.frame_bits == ((sample_precision_field == 2'h0) ? 7'h20 : 7'h40))
        else $error("wrong frame bit count");
    slot_size_a: assert property (@(posedge sys_clk) disable iff (clr)
        (sample_precision_field == 2'h3) |-> cfg.word_bits == 6'h18 && cfg.slot_bits == 6'h20)
        else $error("wrong slot size");
    fixed_clock_a: assert property (@(posedge sys_clk) disable iff (clr)
        mode_r && core_div_we && !wr |=> $stable(div_r))
        else $error("divider moved in fixed mode");
    align_mode_a: assert property (@(posedge sys_clk) disable iff (clr)
        sample_precision_field == 2'h0 |-> !cfg.right_justify)
        else $error("alignment applied to short word");
    reset_value_a: assert property (@(posedge sys_clk)
        clr |=> frac_h_r == 8'h5B && fmt_r == 8'h21 && !run_r)
        else $error("reset value wrong");
    byte_read_a: assert property (@(posedge sys_clk) disable iff (clr)
        host_req.rd && a == aoctr_pkg::OFS_DECODED_FRAMES_MID
        |=> host_rdata == $past(frames_r[15:8]))
        else $error("counter byte read wrong");

    // Core load at frame sync, only while the clock follows the stream
    sequence sync_load_s;
        core_frame_sync && !mode_r && !clr;
    endsequence

    map_write_a: assert property (@(posedge sys_clk) disable iff (clr)
        host_write_s(aoctr_pkg::OFS_CHANNEL_MAPPING) |=> channel_mapping == $past(d[1:0]))
        else $error("channel map not stored");
    host_divider_a: assert property (@(posedge sys_clk) disable iff (clr)
        host_write_s(aoctr_pkg::OFS_PLL_OUTPUT_DIVIDER) ##0 !core_div_we
        |=> cfg.out_div == $past(d[4:0]))
        else $error("host divider write lost");
    core_divider_a: assert property (@(posedge sys_clk) disable iff (clr)
        core_div_we && !mode_r |=> div_r == $past(core_div_value))
        else $error("core divider write lost");
    frac_hold_a: assert property (@(posedge sys_clk) disable iff (clr)
        mode_r && !(wr && a == aoctr_pkg::OFS_PLL_FRACTION_HIGH) |=> $stable(frac_h_r))
        else $error("fraction moved in fixed mode");
    ratio_follow_a: assert property (@(posedge sys_clk) disable iff (clr)
        sync_load_s |=> oversampling_clock_fs_ratio_div == {6'h00, $past(core_oversampling_clock_ratio)})
        else $error("ratio not taken at sync");
    frac_sync_a: assert property (@(posedge sys_clk) disable iff (clr)
        sync_load_s |=> cfg.frac == $past({core_frac_high, core_frac_low}))
        else $error("fraction not taken at sync");
    rate_load_a: assert property (@(posedge sys_clk) disable iff (clr)
        core_frame_done |=> rate_r == $past(core_bitrate_half))
        else $error("bitrate byte not loaded");
    revision_load_a: assert property (@(posedge sys_clk) disable iff (clr)
        core_boot_done |=> fw_r == $past(core_fw_revision))
        else $error("revision byte not loaded");
    treble_store_a: assert property (@(posedge sys_clk) disable iff (clr)
        host_write_s(aoctr_pkg::OFS_HIGH_SHELF_CORNER_LOW) |=> cfg.treble_hz[7:0] == $past(d))
        else $error("treble low byte not stored");
    reset_clear_a: assert property (@(posedge sys_clk)
        clr |=> div_r == aoctr_pkg::RST_PLL_OUTPUT_DIVIDER && map_r == 2'h0 && !mode_r
        && oversampling_clock_fs_ratio_div == 8'h00 && rate_r == 8'h00)
        else $error("reset left a register set");
endmodule

// file: bench/aoctr_host.sv
// Host model that reaches the register bank through its byte port.
// Assumes the bench clock and the design package; drives at falling edges.
`timescale 1ns/100ps
module aoctr_host
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output aoctr_pkg::aoctr_req_t host_req,
    input wire logic [7:0] host_rdata
);
    initial host_req = '0;

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        host_req.wr = 1'b0;
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] q);
        @(negedge sys_clk);
        host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        host_req.rd = 1'b0;
        q = host_rdata;
    endtask
endmodule

// file: bench/audio_output_clock_tone_regs_tb.sv
// Self-checking bench of the audio output clock and tone register bank.
// Assumes the host model aoctr_host and the package aoctr_pkg.
`timescale 1ns/100ps
module audio_output_clock_tone_regs_tb;
    logic sys_clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, div_we = 1'b0;
    logic frm = 1'b0, syn = 1'b0, boot = 1'b0, al, run;
    logic [7:0] rate = 8'h00, fw = 8'h00, fr_lo = 8'h00, fr_hi = 8'h00, q, ratio_div;
    logic [4:0] div_v = 5'h00, dv;
    logic [1:0] ratio = 2'h0, map;
    logic [15:0] sck_div, tf, bf;
    logic [7:0] rst_a[15] = '{8'h55, 8'h56, 8'h61, 8'h63, 8'h65, 8'h67, 8'h68, 8'h69,
        8'h6A, 8'h72, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h80};
    aoctr_pkg::aoctr_req_t host_req;
    aoctr_pkg::aoctr_cfg_t cfg;
    int n_mismatch = 0, compares = 0, cycles = 0, nf;

    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    logic [7:0] q_dut;
    aoctr_host i_host (.sys_clk(sys_clk), .host_req(host_req), .host_rdata(q_dut));
    aoctr_regs i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
        .host_req(host_req), .host_rdata(q_dut), .core_frame_done(frm),
        .core_frame_sync(syn), .core_boot_done(boot), .core_bitrate_half(rate),
        .core_fw_revision(fw), .core_div_we(div_we), .core_div_value(div_v),
        .core_frac_low(fr_lo), .core_frac_high(fr_hi), .core_oversampling_clock_ratio(ratio),
        .cfg(cfg), .channel_mapping(map), .oversampling_clock_fs_ratio_div(ratio_div),
        .sck_half_div(sck_div), .decoding(run));

    // ****************************************
    // Expectations and checks
    // ****************************************
    function automatic logic [5:0] word_of(input logic [1:0] p);
        return p == 2'h0 ? 6'h10 : p == 2'h1 ? 6'h12 : p == 2'h2 ? 6'h14 : 6'h18;
    endfunction

    function automatic logic [7:0] rst_of(input logic [7:0] a);
        return a == 8'h55 ? 8'h21 : a == 8'h65 ? 8'h5B : 8'h00;
    endfunction

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        compares++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.read(a, q);
        chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, q});
    endtask

    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        void'($urandom(48991));
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        foreach (rst_a[i]) rchk(rst_a[i], rst_of(rst_a[i]));
        chk("ratio", 24'(8'h00), 24'(ratio_div));
        chk("sck div", 24'(16'h0004), 24'(sck_div));
        for (int p = 0; p < 4; p++)
        begin
            al = 1'($urandom_range(1, 0));
            i_host.write(8'h55, {3'b001, al, 2'b00, 2'(p)});
            chk("word", 24'(word_of(2'(p))), 24'(cfg.word_bits));
            chk("slots", p == 0 ? 24'h10 : 24'h20, 24'(cfg.slot_bits));
            chk("frame", p == 0 ? 24'h20 : 24'h40, 24'(cfg.frame_bits));
            if (p != 0)
                chk("justify", {23'h000000, ~al}, 24'(cfg.right_justify));
            i_host.write(8'h56, {6'h00, 2'(p)});
            chk("map", 24'(p), 24'(map));
        end
        tf = 16'($urandom_range(23999, 20));
        bf = 16'($urandom_range(750, 21));
        i_host.write(8'h77, tf[7:0]);
        i_host.write(8'h78, tf[15:8]);
        i_host.write(8'h79, bf[7:0]);
        i_host.write(8'h7A, bf[15:8]);
        chk("treble", 24'(tf), 24'(cfg.treble_hz));
        chk("bass", 24'(bf), 24'(cfg.bass_hz));
        rchk(8'h78, tf[15:8]);
        rchk(8'h79, bf[7:0]);
        dv = 5'($urandom);
        i_host.write(8'h61, {3'h0, dv});
        chk("div host", 24'(dv), 24'(cfg.out_div));
        div_v = ~dv;
        pulse(div_we);
        chk("div core", {19'h00000, ~dv}, 24'(cfg.out_div));
        i_host.write(8'h63, 8'h01);
        chk("fixed", 24'h1, 24'(cfg.clock_fixed));
        div_v = dv;
        pulse(div_we);
        chk("div held", {19'h00000, ~dv}, 24'(cfg.out_div));
        i_host.write(8'h64, 8'hA5);
        ratio = 2'h2;
        pulse(syn);
        chk("frac held", {8'h00, rst_of(8'h65), 8'hA5}, 24'(cfg.frac));
        chk("ratio held", 24'h000000, 24'(ratio_div));
        i_host.write(8'h63, 8'h00);
        fr_lo = 8'($urandom);
        fr_hi = 8'($urandom);
        ratio = 2'($urandom_range(2, 0));
        pulse(syn);
        chk("frac", 24'({fr_hi, fr_lo}), 24'(cfg.frac));
        chk("ratio", 24'(ratio), 24'(ratio_div));
        rchk(8'h64, fr_lo);
        nf = $urandom_range(300, 256);
        repeat (nf)
        begin
            rate = 8'($urandom);
            pulse(frm);
        end
        i_host.write(8'h67, 8'hFF);
        rchk(8'h67, nf[7:0]);
        rchk(8'h68, nf[15:8]);
        rchk(8'h69, 8'h00);
        rchk(8'h6A, rate);
        fw = 8'($urandom);
        pulse(boot);
        rchk(8'h71, fw);
        i_host.write(8'h72, 8'h01);
        chk("run", 24'h1, 24'(run));
        chk("cfg run", 24'h1, 24'(cfg.run));
        pulse(soft_rst);
        rchk(8'h67, 8'h00);
        rchk(8'h65, 8'h5B);
        chk("run", 24'h0, 24'(run));
        chk("cfg run", 24'h0, 24'(cfg.run));
        foreach (rst_a[i]) rchk(rst_a[i], rst_of(rst_a[i]));
        complete_run();
    end
endmodule
